/* test/fsd_host.sv */
`timescale 1ns/1ps
module fsd_host
(
    // Clock
    input wire logic clk_sys,
    // Serial pins
    output logic sclk,
    output logic host_d,
    output logic host_oe,
    input wire logic sdio_line
);
    initial
    begin
        sclk = 1'b1;
        host_d = 1'b0;
        host_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Half a serial period, 80 ns; the line clock idles high between bytes
    task automatic half();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    // Address byte then one data byte; data changes after the fall, sampled at the rise
    task automatic xfer(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        host_oe = 1'b1;
        for (i = 15; i >= 0; i--)
        begin
            sclk = 1'b0;
            // Released at the first data fall, before the device drives, so it never fights the host
            if (i < 8 && !a[7])
                host_oe = 1'b0;
            host_d = (i > 7) ? a[i-8] : wd[i];
            half();
            sclk = 1'b1;
            if (i < 8)
                rd[i] = sdio_line;
            half();
        end
        host_oe = 1'b0;
        repeat (20) @(posedge clk_sys);
        #1;
    endtask
endmodule

/* test/fsd_top_test.sv */
`timescale 1ns/1ps
module fsd_top_test;
    import fsd_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic pix_valid = 1'b0;
    logic pix_first = 1'b0;
    logic [5:0] pix_data = 6'h00;
    logic motion_det = 1'b1;
    logic flip = 1'b0;
    logic sclk, host_d, host_oe, sdio_o, sdio_oe, pix_ready, awake;
    fsd_exp_t exposure;
    // Undriven line toggles so a stale bit never reads as a match
    wire logic sdio_line = sdio_oe ? sdio_o : (host_oe ? host_d : flip);
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int exp_min;
    int exp_sum;
    logic [15:0] e_exp = 16'h0100;

    fsd_top #(.SLEEP_CYCLES(200)) u_fsd_top (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
        .sdio_i(sdio_line), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .pix_valid(pix_valid),
        .pix_first(pix_first), .pix_data(pix_data), .pix_ready(pix_ready),
        .motion_det(motion_det), .awake(awake), .exposure(exposure));
    fsd_host u_fsd_host (.clk_sys(clk_sys), .sclk(sclk), .host_d(host_d),
        .host_oe(host_oe), .sdio_line(sdio_line));

    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run needs about 11000 cycles
    always @(posedge clk_sys)
    begin
        flip <= ~flip;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
        samples_checked++;
        if (seen !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task automatic rchk(input string nm, input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_fsd_host.xfer({1'b0, a}, 8'h00, d);
        chk(nm, {8'h00, d}, {8'h00, e});
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] d;
        u_fsd_host.xfer({1'b1, a}, v, d);
    endtask

    function automatic logic [5:0] pv(input int i, input int m);
        if (m == 0)
            return 6'h3f;
        if (m == 1)
            return (i == 100) ? 6'h05 : 6'h28;
        if (m == 2)
            return 6'h0a;
        return 6'((i + m) % 64);
    endfunction

    // One frame in column order, each pixel held until the buffer takes it
    task automatic frame(input int m);
        int i;
        int n;
        exp_min = 63;
        exp_sum = 0;
        for (i = 0; i < 361; i++)
        begin
            pix_valid = 1'b1;
            pix_first = (i == 0);
            pix_data = pv(i, m);
            n = 0;
            // Ready is judged settled, before the edge that would take the pixel
            while (pix_ready !== 1'b1 && n < 50)
            begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            @(posedge clk_sys);
            #1;
            exp_sum += pv(i, m);
            if (pv(i, m) < exp_min)
                exp_min = pv(i, m);
        end
        pix_valid = 1'b0;
        pix_first = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("exposure", exposure, 16'h0100);
        chk("pix_ready", {15'h0000, pix_ready}, 16'h0001);
        rchk("sum", 7'h07, 8'h00);
        rchk("darkest", 7'h06, 8'h3f);
        rchk("exp_hi", 7'h09, 8'h01);
        rchk("exp_lo", 7'h0a, 8'h00);
        wr(7'h09, 8'h55);
        rchk("exp_hi_ro", 7'h09, 8'h01);
        rchk("unmapped", 7'h30, 8'h00);
        rchk("config", 7'h00, 8'h00);
        $display("t_reset done");
    endtask

    task automatic t_stats();
        frame(0);
        e_exp = e_exp - (e_exp >> 4);
        chk("exposure", exposure, e_exp);
        rchk("sum", 7'h07, 8'(exp_sum >> 7));
        rchk("darkest", 7'h06, 8'(exp_min));
        rchk("exp_hi", 7'h09, e_exp[15:8]);
        rchk("exp_lo", 7'h0a, e_exp[7:0]);
        frame(1);
        chk("exposure", exposure, e_exp);
        rchk("sum", 7'h07, 8'(exp_sum >> 7));
        rchk("darkest", 7'h06, 8'(exp_min));
        frame(2);
        rchk("exp_lo_stale", 7'h0a, e_exp[7:0]);
        e_exp = e_exp + (e_exp >> 4);
        chk("exposure", exposure, e_exp);
        rchk("exp_hi", 7'h09, e_exp[15:8]);
        rchk("exp_lo", 7'h0a, e_exp[7:0]);
        $display("t_stats done");
    endtask

    task automatic t_grab();
        wr(7'h00, 8'h10);
        rchk("config", 7'h00, 8'h10);
        wr(7'h08, 8'h5a);
        rchk("dump_armed", 7'h08, 8'h80);
        frame(3);
        // Second frame must not replace the unread sample
        frame(4);
        rchk("dump_p0", 7'h08, 8'hc3);
        frame(5);
        rchk("dump_p1", 7'h08, 8'h46);
        frame(6);
        rchk("dump_p2", 7'h08, 8'h48);
        wr(7'h08, 8'h00);
        frame(7);
        rchk("dump_restart", 7'h08, 8'hc7);
        $display("t_grab done");
    endtask

    task automatic t_sleep();
        motion_det = 1'b0;
        repeat (250) @(posedge clk_sys);
        #1;
        chk("awake_forced", {15'h0000, awake}, 16'h0001);
        wr(7'h00, 8'h00);
        repeat (250) @(posedge clk_sys);
        #1;
        chk("asleep", {15'h0000, awake}, 16'h0000);
        motion_det = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        chk("woken", {15'h0000, awake}, 16'h0001);
        $display("t_sleep done");
    endtask

    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        t_reset();
        t_stats();
        t_grab();
        t_sleep();
        test_done();
    end
endmodule

/* verilog/fsd_cfg.svh */
`ifndef FSD_CFG_SVH
`define FSD_CFG_SVH

// Register offsets
`define FSD_OFS_CONFIG 7'h00
`define FSD_OFS_MINPIX 7'h06
`define FSD_OFS_SUM 7'h07
`define FSD_OFS_DUMP 7'h08
`define FSD_OFS_EXP_HI 7'h09
`define FSD_OFS_EXP_LO 7'h0a

// Field positions and reset values
`define FSD_STAY_AWAKE_BIT 4
`define FSD_RST_MINPIX 8'h3f
`define FSD_RST_SUM 8'h00
`define FSD_RST_EXP 16'h0100

// Frame geometry
`define FSD_PIX_LAST 9'h168
`define FSD_SUM_MAX 8'hb2

// Exposure regulation thresholds
`define FSD_MAX_HI 6'h3c
`define FSD_MAX_LO 6'h20
`define FSD_AVG_HI 8'h8c
`define FSD_AVG_LO 8'h40

// Timing
`define FSD_CLK_MHZ 100
`define FSD_SLEEP_MS 1000
`define FSD_SLEEP_CYCLES (`FSD_SLEEP_MS * `FSD_CLK_MHZ * 1000)
`define FSD_RESYNC_US 10
`define FSD_RESYNC_CYCLES (`FSD_RESYNC_US * `FSD_CLK_MHZ)

`endif

/* verilog/fsd_fifo2.sv */
`timescale 1ns/1ps
module fsd_fifo2 #(
    parameter int W = 7
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [W-1:0] mem [0:1];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic ready_q;
    logic push;
    logic pop;

    assign push = in_valid & ready_q;
    assign pop = out_valid & out_ready;
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem[rp_q];
    assign in_ready = ready_q;

    always_comb
    begin
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + 2'h1;
        else if (pop && !push)
            cnt_d = cnt_q - 2'h1;
    end

    // Ready is registered so the top can hand it straight to the pin
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
            ready_q <= 1'b0;
        end
        else
        begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != 2'h2);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wp_q] <= in_data;
    end

    a_fifo_bound: assert property (@(posedge clk_sys) disable iff (srst)
        cnt_q <= 2'h2)
        else $error("buffer count above two");
endmodule

/* verilog/fsd_pkg.sv */
package fsd_pkg;
    typedef enum logic [2:0]
    {
        FSD_ADDR = 3'h1,
        FSD_WDATA = 3'h2,
        FSD_RDATA = 3'h4
    } fsd_ser_t;

    typedef logic [15:0] fsd_exp_t;
    typedef logic [8:0] fsd_pos_t;
endpackage

/* verilog/fsd_top.sv */
`timescale 1ns/1ps
`include "fsd_cfg.svh"
module fsd_top #(
    parameter int unsigned SLEEP_CYCLES = `FSD_SLEEP_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Two-wire serial port
    input wire logic sclk,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe,
    // Pixel stream from the imager, column-major order
    input wire logic pix_valid,
    input wire logic pix_first,
    input wire logic [5:0] pix_data,
    output logic pix_ready,
    // Power and exposure
    input wire logic motion_det,
    output logic awake,
    output fsd_pkg::fsd_exp_t exposure
);
    import fsd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] sclk_sync_q;
    logic [1:0] sdio_sync_q;
    logic rise;
    logic fall;
    logic sdin;
    fsd_ser_t st_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] dout_q;
    logic oe_q;
    logic [15:0] idle_q;
    logic [6:0] addr_q;
    logic [6:0] addr_now;
    logic rd_fire;
    logic wr_fire;
    logic [7:0] wr_val;
    logic [7:0] rd_val;
    logic rd_dump;
    logic wr_dump;

    logic stay_awake_q;
    logic [7:0] min_rpt_q;
    logic [7:0] sum_rpt_q;
    logic [8:0] idx_q;
    logic valid_q;
    logic [5:0] data_q;
    logic wait_q;
    fsd_exp_t exp_q;
    logic [7:0] low_snap_q;
    logic awake_q;
    logic [31:0] sleep_q;

    // Sample clock and data; data is read from its second stage, clock edges from the second and third
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sclk_sync_q <= 3'h7;
            sdio_sync_q <= 2'h0;
        end
        else
        begin
            sclk_sync_q <= {sclk_sync_q[1:0], sclk};
            sdio_sync_q <= {sdio_sync_q[0], sdio_i};
        end
    end

    assign rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    assign fall = ~sclk_sync_q[1] & sclk_sync_q[2];
    assign sdin = sdio_sync_q[1];
    assign addr_now = {sh_q[5:0], sdin};
    assign rd_fire = (st_q == FSD_ADDR) && rise && (bit_q == 3'h7) && !sh_q[6];
    assign wr_fire = (st_q == FSD_WDATA) && rise && (bit_q == 3'h7);
    assign wr_val = {sh_q[6:0], sdin};
    assign rd_dump = rd_fire && (addr_now == `FSD_OFS_DUMP);
    assign wr_dump = wr_fire && (addr_q == `FSD_OFS_DUMP);

    always_comb
    begin
        case (addr_now)
            `FSD_OFS_CONFIG: rd_val = 8'(stay_awake_q) << `FSD_STAY_AWAKE_BIT;
            `FSD_OFS_MINPIX: rd_val = min_rpt_q;
            `FSD_OFS_SUM: rd_val = sum_rpt_q;
            `FSD_OFS_DUMP: rd_val = {(idx_q == 9'h0), valid_q, data_q};
            `FSD_OFS_EXP_HI: rd_val = exp_q[15:8];
            `FSD_OFS_EXP_LO: rd_val = low_snap_q;
            default: rd_val = 8'h00;
        endcase
    end

    // Idle watchdog realigns to a fresh address byte if the host stops
    always_ff @(posedge clk_sys)
    begin
        if (srst || rise || fall || (st_q == FSD_ADDR && bit_q == 3'h0))
            idle_q <= 16'h0;
        else if (idle_q != 16'(`FSD_RESYNC_CYCLES))
            idle_q <= idle_q + 16'h1;
    end

    // Serial engine: host samples on rising edges, we shift on falling
    always_ff @(posedge clk_sys)
    begin
        if (srst || idle_q == 16'(`FSD_RESYNC_CYCLES))
        begin
            st_q <= FSD_ADDR;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            addr_q <= 7'h00;
            oe_q <= 1'b0;
            dout_q <= 8'h00;
        end
        else
        begin
            case (st_q)
                FSD_ADDR:
                begin
                    if (rise)
                    begin
                        sh_q <= {sh_q[6:0], sdin};
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7)
                        begin
                            addr_q <= addr_now;
                            if (sh_q[6])
                                st_q <= FSD_WDATA;
                            else
                            begin
                                st_q <= FSD_RDATA;
                                dout_q <= rd_val;
                            end
                        end
                    end
                end
                FSD_WDATA:
                begin
                    if (rise)
                    begin
                        sh_q <= {sh_q[6:0], sdin};
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7)
                            st_q <= FSD_ADDR;
                    end
                end
                FSD_RDATA:
                begin
                    // Drive only after the host's falling edge to avoid a fight
                    if (fall)
                    begin
                        if (!oe_q)
                            oe_q <= 1'b1;
                        else
                            dout_q <= {dout_q[6:0], 1'b0};
                    end
                    if (rise && oe_q)
                    begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7)
                        begin
                            st_q <= FSD_ADDR;
                            oe_q <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    st_q <= FSD_ADDR;
                    bit_q <= 3'h0;
                end
            endcase
        end
    end

    assign sdio_o = dout_q[7];
    assign sdio_oe = oe_q;

    ////////////////////////////////////////////////////////////////////////
    logic f_valid;
    logic [6:0] f_data;
    logic f_first;
    logic [5:0] f_pix;
    logic adj_q;
    logic take;
    fsd_pos_t pos_q;
    fsd_pos_t cur_pos;
    logic frame_end;
    logic [14:0] sum_acc_q;
    logic [14:0] sum_nx;
    logic [5:0] min_acc_q;
    logic [5:0] min_nx;
    logic [5:0] max_acc_q;
    logic [5:0] max_nx;
    logic [5:0] max_fr_q;

    // Drain stalls for the one regulation cycle at each frame end
    fsd_fifo2 #(.W(7)) u_buf (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_valid(pix_valid),
        .in_data({pix_first, pix_data}),
        .in_ready(pix_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(!adj_q)
    );

    assign f_first = f_data[6];
    assign f_pix = f_data[5:0];
    assign take = f_valid && !adj_q;
    assign cur_pos = f_first ? 9'h0 : pos_q;
    assign frame_end = take && (cur_pos == `FSD_PIX_LAST);
    assign sum_nx = (f_first ? 15'h0 : sum_acc_q) + 15'(f_pix);
    assign min_nx = (f_first || f_pix < min_acc_q) ? f_pix : min_acc_q;
    assign max_nx = (f_first || f_pix > max_acc_q) ? f_pix : max_acc_q;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pos_q <= 9'h0;
            sum_acc_q <= 15'h0;
            min_acc_q <= 6'h3f;
            max_acc_q <= 6'h0;
        end
        else if (take)
        begin
            pos_q <= cur_pos + 9'h1;
            sum_acc_q <= sum_nx;
            min_acc_q <= min_nx;
            max_acc_q <= max_nx;
        end
    end

    // Reports change only at a complete frame; a short frame reports nothing
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            min_rpt_q <= `FSD_RST_MINPIX;
            sum_rpt_q <= `FSD_RST_SUM;
            max_fr_q <= 6'h0;
            adj_q <= 1'b0;
        end
        else
        begin
            adj_q <= frame_end;
            if (frame_end)
            begin
                min_rpt_q <= {2'b00, min_nx};
                sum_rpt_q <= sum_nx[14:7];
                max_fr_q <= max_nx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Grabber: one pixel per frame, held until the host reads it
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            idx_q <= 9'h0;
            valid_q <= 1'b0;
            data_q <= 6'h0;
            wait_q <= 1'b1;
        end
        else if (wr_dump)
        begin
            idx_q <= 9'h0;
            valid_q <= 1'b0;
            data_q <= 6'h0;
            wait_q <= 1'b1;
        end
        else if (rd_dump)
        begin
            wait_q <= 1'b1;
            if (valid_q)
            begin
                valid_q <= 1'b0;
                idx_q <= (idx_q == `FSD_PIX_LAST) ? 9'h0 : idx_q + 9'h1;
            end
        end
        else if (take && (!wait_q || f_first) && !valid_q)
        begin
            wait_q <= 1'b0;
            if (cur_pos == idx_q)
            begin
                valid_q <= 1'b1;
                data_q <= f_pix;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic too_bright;
    logic too_dark;
    logic [16:0] exp_up;

    assign too_bright = (max_fr_q > `FSD_MAX_HI) || (sum_rpt_q > `FSD_AVG_HI);
    assign too_dark = (max_fr_q < `FSD_MAX_LO) && (sum_rpt_q < `FSD_AVG_LO);
    assign exp_up = {1'b0, exp_q} + {5'h0, exp_q[15:4]};

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            exp_q <= `FSD_RST_EXP;
        else if (adj_q && too_bright)
            exp_q <= exp_q - {4'h0, exp_q[15:4]};
        else if (adj_q && too_dark)
            exp_q <= exp_up[16] ? 16'hffff : exp_up[15:0];
    end

    // Host must read high then low; only a high-byte read refreshes the low snapshot
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            low_snap_q <= 8'(`FSD_RST_EXP);
        else if (rd_fire && addr_now == `FSD_OFS_EXP_HI)
            low_snap_q <= exp_q[7:0];
    end

    assign exposure = exp_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            stay_awake_q <= 1'b0;
        else if (wr_fire && addr_q == `FSD_OFS_CONFIG)
            stay_awake_q <= wr_val[`FSD_STAY_AWAKE_BIT];
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            awake_q <= 1'b1;
            sleep_q <= 32'h0;
        end
        else if (stay_awake_q || motion_det)
        begin
            awake_q <= 1'b1;
            sleep_q <= 32'h0;
        end
        else if (sleep_q >= SLEEP_CYCLES - 32'h1)
            awake_q <= 1'b0;
        else
            sleep_q <= sleep_q + 32'h1;
    end

    assign awake = awake_q;

    ////////////////////////////////////////////////////////////////////////
    sequence s_dump_write;
        wr_dump;
    endsequence

    sequence s_valid_read;
        rd_dump && valid_q && !wr_dump;
    endsequence

    a_min_range: assert property (@(posedge clk_sys) disable iff (srst)
        min_rpt_q[7] == 1'b0)
        else $error("darkest pixel report above 127");
    a_sum_bound: assert property (@(posedge clk_sys) disable iff (srst)
        frame_end |=> sum_rpt_q <= `FSD_SUM_MAX)
        else $error("intensity total above 178");
    a_dump_reset: assert property (@(posedge clk_sys) disable iff (srst)
        s_dump_write |=> idx_q == 9'h0 && !valid_q)
        else $error("dump write did not reset grabber");
    a_first_flag: assert property (@(posedge clk_sys) disable iff (srst)
        rd_dump |-> rd_val[7] == (idx_q == 9'h0))
        else $error("first pixel flag wrong");
    a_read_advance: assert property (@(posedge clk_sys) disable iff (srst)
        s_valid_read |=> idx_q == (($past(idx_q) == `FSD_PIX_LAST) ? 9'h0
            : $past(idx_q) + 9'h1))
        else $error("dump read did not advance index");
    a_hold_sample: assert property (@(posedge clk_sys) disable iff (srst)
        valid_q && !rd_dump && !wr_dump |=> valid_q && $stable(data_q))
        else $error("held sample changed before read");
    a_exp_reset: assert property (@(posedge clk_sys)
        srst |=> exp_q == `FSD_RST_EXP)
        else $error("exposure reset value wrong");
    a_exp_once: assert property (@(posedge clk_sys) disable iff (srst)
        !adj_q |=> $stable(exp_q))
        else $error("exposure changed outside frame end");
    a_exp_step: assert property (@(posedge clk_sys) disable iff (srst)
        adj_q && too_bright |=> exp_q == $past(exp_q) - ($past(exp_q) >> 4))
        else $error("exposure step not one sixteenth");
    a_low_snap: assert property (@(posedge clk_sys) disable iff (srst)
        rd_fire && addr_now == `FSD_OFS_EXP_HI |=> low_snap_q == $past(exp_q[7:0]))
        else $error("low byte not snapshot");
    a_stay_awake: assert property (@(posedge clk_sys) disable iff (srst)
        stay_awake_q |=> awake_q [*2])
        else $error("sensor slept while forced awake");
endmodule
